// ==== logic/low_voltage_power_mgmt_ctrl.sv ====
// How it works
// [RULE1] Boot software writes both power registers after every reset to lock them.
// [RULE2] Warning flag sets when the supply is below the warning level, also after reset; here it sets only while detect_active is high.
// [RULE3] Writing one to warning_ack clears the flag only if the warning has gone.
// [RULE4] With warning_irq_enable set, interrupt is requested while the warning flag is set.
// [RULE5] Write-once detect_reset_enable lets an enabled detect event force a reset.
// [RULE6] detect_stop_enable keeps detection running in stop mode, or turns it off.
// [RULE7] Write-once detect_enable switches detection on; reset and stop enables need it.
// [RULE8] bandgap_buffer_enable switches the bandgap buffer for the ADC channel.
// [RULE9] Write-once bits take the first write after reset and ignore later ones.
// [RULE10] Write-once detect_range_select picks the detect level and the warning pair.
// [RULE11] warning_level_select picks one of the two warning levels in that pair.
// [RULE12] Range and level selects decode together into one threshold code.
// [RULE13] stop2_recovered_flag reads one after recovery from stop2 partial power-down.
// [RULE14] Writing one to stop2_recovery_ack clears the stop2 recovery flag.
// [RULE15] Write-once stop2_select: zero picks stop3, one picks stop2.
// [RULE16] After stop2 software checks the flag, restores I/O, then acknowledges.
// [RULE17] Both acknowledge bits are write-one strobes and always read back zero.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`default_nettype none
module low_voltage_power_mgmt_ctrl
    import pwr_mgmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog comparator levels and stop-mode status
    input wire logic undervoltage_warning,
    input wire logic undervoltage_detect,
    input wire logic in_stop,
    input wire logic stop2_wakeup,
    // Controls toward the analog and stop-mode logic
    output logic detect_active,
    output logic detect_reset_req,
    output logic bandgap_buffer_enable,
    output logic detect_level_high,
    output logic [1:0] threshold_code,
    output logic stop2_select,
    output logic irq
);

    typedef struct packed {
        logic warning_flag;
        logic warning_irq_enable;
        logic detect_stop_enable;
        logic bandgap_buffer_enable;
        logic warning_level_select;
        logic stop2_recovered_flag;
        logic detect_reset_req;
        logic [IRQ_WIDTH-1:0] irq_status;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic [31:0] prdata;
        logic pslverr;
    } state_t;

    state_t s;
    state_t next_s;

    // Bus phase decode
    logic setup_phase;
    logic access_write;
    logic low_lane;
    logic hit_one;
    logic hit_two;
    logic hit_status;
    logic hit_mask;
    logic mapped;
    logic write_one;
    logic write_two;
    logic write_status;
    logic write_mask;

    // Write-once bit array
    logic [WO_COUNT-1:0] wo_wr;
    logic [WO_COUNT-1:0] wo_wdata;
    logic [WO_COUNT-1:0] wo_value;

    // Live views of the locked controls
    logic detect_reset_enable;
    logic detect_enable;
    logic detect_range_select;
    logic detect_event;
    logic warning_clear;
    logic stop2_clear;
    logic [IRQ_WIDTH-1:0] events;
    logic [7:0] reg_one_view;
    logic [7:0] reg_two_view;

    // Setup latches read data; access commits writes, so pready can stay high
    assign setup_phase = psel && !penable;
    assign low_lane = pstrb[0];
    assign access_write = psel && penable && pwrite && low_lane;
    assign hit_one = (paddr == REG_ONE_OFFSET);
    assign hit_two = (paddr == REG_TWO_OFFSET);
    assign hit_status = (paddr == IRQ_STATUS_OFFSET);
    assign hit_mask = (paddr == IRQ_MASK_OFFSET);
    assign mapped = hit_one || hit_two || hit_status || hit_mask;
    assign write_one = access_write && hit_one;
    assign write_two = access_write && hit_two;
    assign write_status = access_write && hit_status;
    assign write_mask = access_write && hit_mask;

    // Any write with the low byte strobe counts as its first write, whatever the value
    assign wo_wr[WO_DETECT_RESET] = write_one; // [RULE9]
    assign wo_wr[WO_DETECT_ENABLE] = write_one; // [RULE9]
    assign wo_wr[WO_RANGE_SELECT] = write_two; // [RULE9]
    assign wo_wr[WO_STOP2_SELECT] = write_two; // [RULE9]
    assign wo_wdata[WO_DETECT_RESET] = pwdata[DETECT_RESET_ENABLE_BIT];
    assign wo_wdata[WO_DETECT_ENABLE] = pwdata[DETECT_ENABLE_BIT];
    assign wo_wdata[WO_RANGE_SELECT] = pwdata[DETECT_RANGE_SELECT_BIT];
    assign wo_wdata[WO_STOP2_SELECT] = pwdata[STOP2_SELECT_BIT];

    // Reset defaults only hold until boot code writes each register
    generate
        for (genvar i = 0; i < WO_COUNT; i++) begin : g_write_once
            write_once_bit #(
                .RESET_VALUE(WO_RESET[i])
            ) u_bit (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .wr_en(wo_wr[i]),
                .wr_data(wo_wdata[i]),
                .value(wo_value[i])
            );
        end
    endgenerate

    assign detect_reset_enable = wo_value[WO_DETECT_RESET];
    assign detect_enable = wo_value[WO_DETECT_ENABLE];
    assign detect_range_select = wo_value[WO_RANGE_SELECT];
    assign stop2_select = wo_value[WO_STOP2_SELECT]; // [RULE15]

    // Detection runs when enabled, and in stop only if stop enable says so
    assign detect_active = detect_enable && (!in_stop || s.detect_stop_enable); // [RULE6] [RULE7]

    // Detect event qualified by the enable chain
    assign detect_event = detect_active && undervoltage_detect;

    // Ack strobes; the warning ack is refused while the warning persists
    assign warning_clear = write_one && pwdata[WARNING_ACK_BIT] && !undervoltage_warning; // [RULE3]
    assign stop2_clear = write_two && pwdata[STOP2_RECOVERY_ACK_BIT]; // [RULE14]

    // Sticky event sources for the interrupt status register
    always_comb begin
        events = '0;
        events[EVT_WARNING_BIT] = detect_active && undervoltage_warning && !s.warning_flag;
        events[EVT_DETECT_BIT] = detect_event;
        events[EVT_STOP2_BIT] = stop2_wakeup;
    end

    // Read images; ack bits and unused bits read as zero
    always_comb begin
        reg_one_view = 8'h00;
        reg_one_view[WARNING_FLAG_BIT] = s.warning_flag;
        reg_one_view[WARNING_IRQ_ENABLE_BIT] = s.warning_irq_enable;
        reg_one_view[DETECT_RESET_ENABLE_BIT] = detect_reset_enable;
        reg_one_view[DETECT_STOP_ENABLE_BIT] = s.detect_stop_enable;
        reg_one_view[DETECT_ENABLE_BIT] = detect_enable;
        reg_one_view[BANDGAP_BUFFER_ENABLE_BIT] = s.bandgap_buffer_enable; // [RULE17]
        reg_two_view = 8'h00;
        reg_two_view[DETECT_RANGE_SELECT_BIT] = detect_range_select;
        reg_two_view[WARNING_LEVEL_SELECT_BIT] = s.warning_level_select;
        reg_two_view[STOP2_RECOVERED_FLAG_BIT] = s.stop2_recovered_flag; // [RULE13] [RULE17]
        reg_two_view[STOP2_SELECT_BIT] = stop2_select;
    end

    // Whole next state of the block
    always_comb begin
        next_s = s;

        // Warning flag: the set term wins over an ack in the same cycle
        if (detect_active && undervoltage_warning) begin // [RULE2]
            next_s.warning_flag = 1'h1;
        end else if (warning_clear) begin // [RULE3]
            next_s.warning_flag = 1'h0;
        end

        // Stop2 recovery flag: wakeup wins over a simultaneous ack
        if (stop2_wakeup) begin // [RULE13]
            next_s.stop2_recovered_flag = 1'h1;
        end else if (stop2_clear) begin // [RULE14]
            next_s.stop2_recovered_flag = 1'h0;
        end

        // Freely writable controls of the first register
        if (write_one) begin
            next_s.warning_irq_enable = pwdata[WARNING_IRQ_ENABLE_BIT]; // [RULE4]
            next_s.detect_stop_enable = pwdata[DETECT_STOP_ENABLE_BIT]; // [RULE6]
            next_s.bandgap_buffer_enable = pwdata[BANDGAP_BUFFER_ENABLE_BIT]; // [RULE8]
        end

        // Warning level select stays writable after the range is locked
        if (write_two) begin
            next_s.warning_level_select = pwdata[WARNING_LEVEL_SELECT_BIT]; // [RULE11]
        end

        // Reset request held while an enabled detect condition lasts
        next_s.detect_reset_req = detect_event && detect_reset_enable; // [RULE5] [RULE7]

        // Interrupt status: write one to clear, new events win
        if (write_status) begin
            next_s.irq_status = s.irq_status & ~pwdata[IRQ_WIDTH-1:0];
        end
        next_s.irq_status = next_s.irq_status | events;

        if (write_mask) begin
            next_s.irq_mask = pwdata[IRQ_WIDTH-1:0];
        end

        // Read data and error taken in setup, held through access
        if (setup_phase) begin
            next_s.pslverr = !mapped;
            next_s.prdata = PRDATA_RESET;
            if (!pwrite) begin
                if (hit_one) begin
                    next_s.prdata[7:0] = reg_one_view;
                end else if (hit_two) begin
                    next_s.prdata[7:0] = reg_two_view;
                end else if (hit_status) begin
                    next_s.prdata[IRQ_WIDTH-1:0] = s.irq_status;
                end else if (hit_mask) begin
                    next_s.prdata[IRQ_WIDTH-1:0] = s.irq_mask;
                end
            end
        end
    end

    // Single register stage for all block state outside the write-once bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s.warning_flag <= WARNING_FLAG_RESET;
            s.warning_irq_enable <= WARNING_IRQ_ENABLE_RESET;
            s.detect_stop_enable <= DETECT_STOP_ENABLE_RESET;
            s.bandgap_buffer_enable <= BANDGAP_BUFFER_ENABLE_RESET;
            s.warning_level_select <= WARNING_LEVEL_SELECT_RESET;
            s.stop2_recovered_flag <= STOP2_RECOVERED_FLAG_RESET;
            s.detect_reset_req <= 1'h0;
            s.irq_status <= IRQ_STATUS_RESET;
            s.irq_mask <= IRQ_MASK_RESET;
            s.prdata <= PRDATA_RESET;
            s.pslverr <= 1'h0;
        end else begin
            s <= next_s;
        end
    end

    // Zero wait states; error only reported in access phase
    assign pready = 1'h1;
    assign prdata = s.prdata;
    assign pslverr = s.pslverr && psel && penable;

    // Threshold decode: range bit picks detect level and warning pair
    assign detect_level_high = detect_range_select; // [RULE10] [RULE12]
    assign threshold_code = {detect_range_select, s.warning_level_select}; // [RULE11] [RULE12]

    assign bandgap_buffer_enable = s.bandgap_buffer_enable; // [RULE8]
    assign detect_reset_req = s.detect_reset_req;

    // Warning request is level, not sticky, so it drops once acked
    assign irq = (s.warning_flag && s.warning_irq_enable) || (|(s.irq_status & s.irq_mask)); // [RULE4]

endmodule : low_voltage_power_mgmt_ctrl
`default_nettype wire

// ==== logic/pwr_mgmt_pkg.sv ====
`default_nettype none
package pwr_mgmt_pkg;

    // APB word offsets of the four software-visible registers
    localparam logic [11:0] REG_ONE_OFFSET = 12'h000;
    localparam logic [11:0] REG_TWO_OFFSET = 12'h004;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'h00c;

    // Field positions in power_mgmt_reg_one
    localparam int WARNING_FLAG_BIT = 7;
    localparam int WARNING_ACK_BIT = 6;
    localparam int WARNING_IRQ_ENABLE_BIT = 5;
    localparam int DETECT_RESET_ENABLE_BIT = 4;
    localparam int DETECT_STOP_ENABLE_BIT = 3;
    localparam int DETECT_ENABLE_BIT = 2;
    localparam int BANDGAP_BUFFER_ENABLE_BIT = 0;

    // Field positions in power_mgmt_reg_two
    localparam int DETECT_RANGE_SELECT_BIT = 5;
    localparam int WARNING_LEVEL_SELECT_BIT = 4;
    localparam int STOP2_RECOVERED_FLAG_BIT = 3;
    localparam int STOP2_RECOVERY_ACK_BIT = 2;
    localparam int STOP2_SELECT_BIT = 0;

    // Event bits shared by the interrupt status and mask registers
    localparam int IRQ_WIDTH = 3;
    localparam int EVT_WARNING_BIT = 0;
    localparam int EVT_DETECT_BIT = 1;
    localparam int EVT_STOP2_BIT = 2;

    // Write-once bit slots inside the lock module array
    localparam int WO_COUNT = 4;
    localparam int WO_DETECT_RESET = 0;
    localparam int WO_DETECT_ENABLE = 1;
    localparam int WO_RANGE_SELECT = 2;
    localparam int WO_STOP2_SELECT = 3;

    // Reset values
    localparam logic [WO_COUNT-1:0] WO_RESET = 4'h3;
    localparam logic WARNING_FLAG_RESET = 1'h0;
    localparam logic WARNING_IRQ_ENABLE_RESET = 1'h0;
    localparam logic DETECT_STOP_ENABLE_RESET = 1'h0;
    localparam logic BANDGAP_BUFFER_ENABLE_RESET = 1'h0;
    localparam logic WARNING_LEVEL_SELECT_RESET = 1'h0;
    localparam logic STOP2_RECOVERED_FLAG_RESET = 1'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_STATUS_RESET = 3'h0;
    localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
    localparam logic [31:0] PRDATA_RESET = 32'h0000_0000;

endpackage : pwr_mgmt_pkg
`default_nettype wire

// ==== logic/write_once_bit.sv ====
`default_nettype none
module write_once_bit
    import pwr_mgmt_pkg::*;
#(
    parameter logic RESET_VALUE = 1'h0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic wr_data,
    output logic value
);

    typedef struct packed {
        logic locked;
        logic value;
    } wo_state_t;

    wo_state_t s;
    wo_state_t next_s;

    // First write after reset lands and locks; later writes are dropped
    always_comb begin
        next_s = s;
        if (wr_en && !s.locked) begin // [RULE9]
            next_s.value = wr_data;
            next_s.locked = 1'h1;
        end
    end

    // Only a system reset reopens the bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s.locked <= 1'h0;
            s.value <= RESET_VALUE;
        end else begin
            s <= next_s;
        end
    end

    assign value = s.value;

endmodule : write_once_bit
`default_nettype wire

// ==== bench/pwr_mgmt_props.sv ====
`default_nettype none
module pwr_mgmt_props
    import pwr_mgmt_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic undervoltage_detect,
    input wire logic detect_active,
    input wire logic detect_reset_req,
    input wire logic bandgap_buffer_enable,
    input wire logic detect_level_high,
    input wire logic [1:0] threshold_code,
    input wire logic stop2_select
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lock_two;
    logic wr_one;
    logic wr_two;

    // Writes commit at the access edge, low byte strobe only
    assign wr_one = psel && penable && pwrite && pstrb[0] && paddr == REG_ONE_OFFSET;
    assign wr_two = psel && penable && pwrite && pstrb[0] && paddr == REG_TWO_OFFSET;

    // Lock follows the first accepted write; only reset clears it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_two <= 1'b0;
        end else if (wr_two) begin
            lock_two <= 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // First write after reset, and an enabled detect event
    sequence s_first_two;
        wr_two && !lock_two;
    endsequence
    sequence s_detect_event;
        detect_active && undervoltage_detect;
    endsequence

    stop_select_first_a:
        assert property (s_first_two |=> stop2_select == $past(pwdata[0]))
        else $error("stop select differs from first write");
    range_first_a:
        assert property (s_first_two |=> detect_level_high == $past(pwdata[5]))
        else $error("range select differs from first write");
    locked_two_a:
        assert property (lock_two |=> $stable(stop2_select) && $stable(detect_level_high))
        else $error("locked select changed");
    level_select_a:
        assert property (wr_two |=> threshold_code[0] == $past(pwdata[4]))
        else $error("warning level select not written");
    code_pair_a:
        assert property (s_first_two |=> threshold_code == $past(pwdata[5:4]))
        else $error("threshold code range mismatch");
    bandgap_write_a:
        assert property (wr_one |=> bandgap_buffer_enable == $past(pwdata[0]))
        else $error("bandgap enable not written");
    reset_cause_a:
        assert property (detect_reset_req |-> $past(detect_active && undervoltage_detect))
        else $error("reset request without detect event");
    detect_off_a:
        assert property (!detect_active |=> !detect_reset_req)
        else $error("reset request with detection off");
    ack_zero_a:
        assert property (psel && penable && !pwrite |-> !(paddr == REG_ONE_OFFSET && prdata[6])
            && !(paddr == REG_TWO_OFFSET && prdata[2]))
        else $error("acknowledge bit read as one");
    cover property (s_detect_event ##1 detect_reset_req);
endmodule : pwr_mgmt_props

bind low_voltage_power_mgmt_ctrl pwr_mgmt_props props_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .undervoltage_detect(undervoltage_detect), .detect_active(detect_active),
    .detect_reset_req(detect_reset_req), .bandgap_buffer_enable(bandgap_buffer_enable),
    .detect_level_high(detect_level_high), .threshold_code(threshold_code), .stop2_select(stop2_select));
`default_nettype wire

// ==== bench/low_voltage_power_mgmt_ctrl_bench.sv ====
`default_nettype none
module low_voltage_power_mgmt_ctrl_bench
    import pwr_mgmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
    logic uvw, uvd, in_stop, wake, da, req, bg, lvl_hi, s2sel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data, d1, d2;
    logic [3:0] pstrb;
    logic [1:0] tcode;
    logic [7:0] e1, cfg;
    logic [7:0] cfg_tab [4] = '{8'h1c, 8'h14, 8'h10, 8'h0c};
    int n_fail = 0, cmp_count = 0, cycles = 0, seed = 26971;

    low_voltage_power_mgmt_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .undervoltage_warning(uvw), .undervoltage_detect(uvd), .in_stop(in_stop),
        .stop2_wakeup(wake), .detect_active(da), .detect_reset_req(req), .bandgap_buffer_enable(bg),
        .detect_level_high(lvl_hi), .threshold_code(tcode), .stop2_select(s2sel), .irq(irq));

    // Free-running clock, 5 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Watchdog: the whole run needs well under a few thousand cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] expected);
        cmp_count++;
        if (seen !== expected) begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd_data = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task do_reset;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        uvd <= 1'b0;
        in_stop <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
    endtask : do_reset

    // Write-once bits keep the first value, the others the last
    function logic [7:0] merge(input logic [7:0] first, later, wo, rw);
        return (first & wo) | (later & rw);
    endfunction : merge

    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb, uvw, uvd, in_stop, wake} = '0;
        rst_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, REG_ONE_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h14);
        apb(1'b0, 12'h010, 32'h0, 4'h0);
        check(32'(err), 32'h1);
        check(32'(pready), 32'h1);
        $display("test reset_values done");
        // Random first and second writes, first one masked by strobe
        repeat (6) begin
            d1 = $random(seed);
            d2 = $random(seed);
            do_reset();
            apb(1'b1, REG_ONE_OFFSET, ~d1, 4'h0);
            apb(1'b1, REG_ONE_OFFSET, d1 & 32'h3d, 4'h1);
            apb(1'b1, REG_ONE_OFFSET, d2 & 32'h3d, 4'h1);
            e1 = merge(d1[7:0], d2[7:0], 8'h14, 8'h29);
            apb(1'b0, REG_ONE_OFFSET, 32'h0, 4'h0);
            check(rd_data, 32'(e1));
            check(32'(bg), 32'(e1[0]));
            apb(1'b1, REG_TWO_OFFSET, d1 & 32'h31, 4'h1);
            apb(1'b1, REG_TWO_OFFSET, d2 & 32'h31, 4'h1);
            e1 = merge(d1[7:0], d2[7:0], 8'h21, 8'h10);
            apb(1'b0, REG_TWO_OFFSET, 32'h0, 4'h0);
            check(rd_data, 32'(e1));
            check(32'(lvl_hi), 32'(e1[5]));
            check(32'({tcode, s2sel}), 32'({e1[5], e1[4], e1[0]}));
        end
        $display("test write_once done");
        // Detect enable, stop enable and reset enable combinations
        for (int i = 0; i < 4; i++) begin
            cfg = cfg_tab[i];
            do_reset();
            apb(1'b1, REG_ONE_OFFSET, 32'(cfg), 4'h1);
            in_stop <= 1'b1;
            uvd <= 1'b1;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check(32'(da), 32'(cfg[2] & cfg[3]));
            check(32'(req), 32'(cfg[2] & cfg[3] & cfg[4]));
            @(posedge ref_clk);
            in_stop <= 1'b0;
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            check(32'(req), 32'(cfg[2] & cfg[4]));
        end
        $display("test detect_controls done");
        // Warning flag, acknowledge refused while present, interrupt path
        do_reset();
        apb(1'b1, REG_ONE_OFFSET, 32'h24, 4'h1);
        @(posedge ref_clk);
        uvw <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check(32'(irq), 32'h1);
        apb(1'b1, REG_ONE_OFFSET, 32'h64, 4'h1);
        apb(1'b0, REG_ONE_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'ha4);
        @(posedge ref_clk);
        uvw <= 1'b0;
        apb(1'b1, REG_ONE_OFFSET, 32'h64, 4'h1);
        apb(1'b0, REG_ONE_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h24);
        apb(1'b0, IRQ_STATUS_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h1);
        apb(1'b1, IRQ_MASK_OFFSET, 32'h1, 4'h1);
        @(negedge ref_clk);
        check(32'(irq), 32'h1);
        apb(1'b1, IRQ_STATUS_OFFSET, 32'h1, 4'h1);
        @(negedge ref_clk);
        check(32'(irq), 32'h0);
        $display("test warning done");
        // Stop2 recovery flag and its acknowledge
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        apb(1'b0, REG_TWO_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h08);
        apb(1'b1, REG_TWO_OFFSET, 32'h04, 4'h1);
        apb(1'b0, REG_TWO_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h0);
        $display("test stop2_flag done");
        // Supply already below the warning level when reset ends
        uvw <= 1'b1;
        do_reset();
        apb(1'b0, REG_ONE_OFFSET, 32'h0, 4'h0);
        check(rd_data, 32'h94);
        uvw <= 1'b0;
        $display("test warning_at_reset done");
        complete_run();
    end
endmodule : low_voltage_power_mgmt_ctrl_bench
`default_nettype wire
